// *** core/asbp_pkg.sv ***
package asbp_pkg;

    // Register indices (printed offsets are not word aligned: byte address = index * 4)
    localparam logic [15:0] REG_RX_PEEK_IDX  = 16'h7056;
    localparam logic [15:0] REG_RX_DATA_IDX  = 16'h7057;
    localparam logic [15:0] REG_TX_DATA_IDX  = 16'h7059;
    localparam logic [15:0] REG_PIN_CTRL_IDX = 16'h705e;
    localparam logic [15:0] REG_PRIO_IDX     = 16'h705f;
    localparam logic [15:0] REG_STATUS_IDX   = 16'h7060;
    localparam logic [15:0] REG_CONTROL_IDX  = 16'h7061;
    localparam logic [15:0] REG_IRQ_STAT_IDX = 16'h7062;
    localparam logic [15:0] REG_IRQ_MASK_IDX = 16'h7063;

    // Pin control fields
    localparam int PC_TX_IN   = 7;
    localparam int PC_TX_OUT  = 6;
    localparam int PC_TX_FUNC = 5;
    localparam int PC_TX_DIR  = 4;
    localparam int PC_RX_IN   = 3;
    localparam int PC_RX_OUT  = 2;
    localparam int PC_RX_FUNC = 1;
    localparam int PC_RX_DIR  = 0;

    // Priority fields
    localparam int PR_TX_LEVEL = 6;
    localparam int PR_RX_LEVEL = 5;
    localparam int PR_FREEZE   = 4;

    // Status fields
    localparam int ST_RX_READY = 0;
    localparam int ST_TX_READY = 1;
    localparam int ST_WAKEUP   = 2;
    localparam int ST_OVERRUN  = 3;

    // Control fields
    localparam int CT_SOFT_RESET = 0;
    localparam int CT_RX_IRQ_EN  = 1;
    localparam int CT_TX_IRQ_EN  = 2;
    localparam int CT_ADDR_MODE  = 3;
    localparam int CT_IDLE_MODE  = 4;

    // Interrupt status fields
    localparam int IS_RX = 0;
    localparam int IS_TX = 1;

    localparam logic [7:0] RESET_BYTE     = 8'h00;
    localparam logic [7:0] PIN_CTRL_WMASK = 8'h77;
    localparam logic [7:0] PRIO_WMASK     = 8'h70;
    localparam logic [7:0] CONTROL_WMASK  = 8'h1f;

    typedef enum logic [1:0] {
        ASBP_IDLE = 2'b01,
        ASBP_RESP = 2'b10
    } asbp_bus_e;

    // Character handed over by the receive shifter
    typedef struct packed {
        logic       valid;
        logic       addr_bit;
        logic [7:0] data;
    } asbp_rx_char_s;

endpackage

// *** core/asbp_core.sv ***
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
module asbp_core
    import asbp_pkg::*;
(
    // Clock and reset
    input  wire logic          i_sys_clk,
    input  wire logic          i_rst_n,
    // Avalon-MM slave
    input  wire logic [17:0]   i_avs_address,
    input  wire logic          i_avs_read,
    input  wire logic          i_avs_write,
    input  wire logic [31:0]   i_avs_writedata,
    output logic [31:0]        o_avs_readdata,
    output logic               o_avs_waitrequest,
    output logic [1:0]         o_avs_response,
    // Receive shifter hand-over and line state
    input  wire asbp_rx_char_s i_rx_char,
    input  wire logic          i_rx_line_idle,
    // Transmit shifter hand-over
    input  wire logic          i_tx_shift_free,
    output logic               o_tx_load,
    output logic [7:0]         o_tx_shift_reg,
    input  wire logic          i_tx_serial,
    // Emulator suspend
    input  wire logic          i_suspend,
    input  wire logic          i_shift_busy,
    output logic               o_freeze,
    // Pins
    input  wire logic          i_tx_pin,
    output logic               o_tx_pin,
    output logic               o_tx_pin_oe,
    input  wire logic          i_rx_pin,
    output logic               o_rx_pin,
    output logic               o_rx_pin_oe,
    output logic               o_rx_serial,
    // Interrupts
    output logic               o_rx_irq,
    output logic               o_tx_irq,
    output logic               o_rx_irq_low_prio,
    output logic               o_tx_irq_low_prio,
    output logic               o_irq
);

    asbp_bus_e   bus_state;
    logic [7:0]  rx_buffer;
    logic        rx_addr_bit;
    logic        rx_char_ready_flag;
    logic        tx_buffer_ready_flag;
    logic        wakeup_detect_flag;
    logic        overrun_flag;
    logic        after_address;
    logic [7:0]  tx_data_buffer;
    logic [7:0]  pin_control;
    logic [7:0]  irq_priority;
    logic [7:0]  control;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic [15:0] req_idx;
    logic        acc_wr;
    logic        acc_rd;
    logic        rd_data_hit;
    logic        soft_rst;
    logic        freeze_now;
    logic        rx_load;
    logic        tx_xfer;
    logic [7:0]  wdata;
    logic [7:0]  next_rdata;
    logic        next_hit;

    // Avalon word address carries the register index directly (byte address / 4)
    assign req_idx  = i_avs_address[15:0];
    assign wdata    = i_avs_writedata[7:0];
    // Side effects land on the answering edge, when the master sees waitrequest low
    assign acc_wr   = i_avs_write && bus_state == ASBP_RESP;
    assign acc_rd   = i_avs_read && bus_state == ASBP_RESP;
    assign soft_rst = control[CT_SOFT_RESET];
    assign freeze_now = i_suspend && (irq_priority[PR_FREEZE] || !i_shift_busy);
    assign rx_load  = i_rx_char.valid && !freeze_now && !soft_rst;
    assign tx_xfer  = !tx_buffer_ready_flag && i_tx_shift_free && !freeze_now && !soft_rst;
    assign rd_data_hit = acc_rd && req_idx == REG_RX_DATA_IDX;

    // One wait cycle per access: request taken in IDLE, answered in RESP
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state         <= ASBP_IDLE;
            o_avs_waitrequest <= 1'b1;
        end else begin
            case (bus_state)
                ASBP_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_state         <= ASBP_RESP;
                        o_avs_waitrequest <= 1'b0;
                    end
                end
                ASBP_RESP: begin
                    bus_state         <= ASBP_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state         <= ASBP_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        next_hit   = 1'b1;
        next_rdata = 8'h00;
        case (req_idx)
            REG_RX_PEEK_IDX: next_rdata = rx_buffer;
            REG_RX_DATA_IDX: next_rdata = rx_buffer;
            REG_TX_DATA_IDX: next_rdata = tx_data_buffer;
            REG_PIN_CTRL_IDX: begin
                next_rdata = pin_control;
                next_rdata[PC_TX_IN] = i_tx_pin;
                next_rdata[PC_RX_IN] = i_rx_pin;
            end
            REG_PRIO_IDX:     next_rdata = irq_priority;
            REG_STATUS_IDX: begin
                next_rdata[ST_RX_READY] = rx_char_ready_flag;
                next_rdata[ST_TX_READY] = tx_buffer_ready_flag;
                next_rdata[ST_WAKEUP]   = wakeup_detect_flag;
                next_rdata[ST_OVERRUN]  = overrun_flag;
            end
            REG_CONTROL_IDX:  next_rdata = control;
            REG_IRQ_STAT_IDX: next_rdata = {6'h00, irq_status};
            REG_IRQ_MASK_IDX: next_rdata = {6'h00, irq_mask};
            default:          next_hit = 1'b0;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
            o_avs_response <= 2'h0;
        end else if (bus_state == ASBP_IDLE && (i_avs_read || i_avs_write)) begin
            // Read data captured on the taking edge so it stands when answered
            o_avs_readdata <= i_avs_read ? {24'h000000, next_rdata} : 32'h0000_0000;
            o_avs_response <= next_hit ? 2'h0 : 2'h3;
        end
    end

    // Configuration registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_control  <= RESET_BYTE;
            irq_priority <= RESET_BYTE;
            control      <= RESET_BYTE;
            irq_mask     <= 2'h0;
        end else if (acc_wr) begin
            if (req_idx == REG_PRIO_IDX)
                irq_priority <= wdata & PRIO_WMASK;
            if (req_idx == REG_PIN_CTRL_IDX)
                pin_control <= wdata & PIN_CTRL_WMASK;
            if (req_idx == REG_CONTROL_IDX)
                control <= wdata & CONTROL_WMASK;
            if (req_idx == REG_IRQ_MASK_IDX)
                irq_mask <= wdata[1:0];
        end
    end

    // Receive buffer and flags
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_buffer          <= RESET_BYTE;
            rx_addr_bit        <= 1'b0;
            rx_char_ready_flag <= 1'b0;
            overrun_flag       <= 1'b0;
        end else if (soft_rst) begin
            rx_char_ready_flag <= 1'b0;
            overrun_flag       <= 1'b0;
        end else if (rx_load) begin
            // ready on load; a simultaneous read loses to the load
            rx_buffer          <= i_rx_char.data;
            rx_addr_bit        <= i_rx_char.addr_bit;
            rx_char_ready_flag <= 1'b1;
            if (rx_char_ready_flag && !rd_data_hit)
                overrun_flag <= 1'b1;
        end else if (rd_data_hit) begin
            // only the normal address clears ready
            rx_char_ready_flag <= 1'b0;
        end
    end

    // Wakeup detect
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wakeup_detect_flag <= 1'b0;
            after_address      <= 1'b0;
        end else if (soft_rst) begin
            wakeup_detect_flag <= 1'b0;
            after_address      <= 1'b0;
        end else if (control[CT_ADDR_MODE]) begin
            // track address bit of buffered character
            if (rx_load)
                wakeup_detect_flag <= i_rx_char.addr_bit;
            else if (rd_data_hit)
                wakeup_detect_flag <= 1'b0;
        end else if (control[CT_IDLE_MODE]) begin
            // idle line sets, set wins over clears
            if (i_rx_line_idle && !freeze_now) begin
                wakeup_detect_flag <= 1'b1;
                after_address      <= 1'b1;
            end else if (rx_load && after_address) begin
                // first byte after the idle line clears
                after_address <= 1'b0;
                wakeup_detect_flag <= 1'b0;
            end else if (rd_data_hit) begin
                wakeup_detect_flag <= 1'b0;
            end
        end else if (rd_data_hit) begin
            wakeup_detect_flag <= 1'b0;
        end
    end

    // Transmit buffer and hand-off
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_data_buffer       <= RESET_BYTE;
            tx_buffer_ready_flag <= 1'b1;
            o_tx_load            <= 1'b0;
            o_tx_shift_reg       <= RESET_BYTE;
        end else begin
            o_tx_load <= tx_xfer;
            if (soft_rst) begin
                tx_buffer_ready_flag <= 1'b1;
            end else if (acc_wr && req_idx == REG_TX_DATA_IDX) begin
                // full byte stored; all eight bits go to the shifter
                tx_data_buffer       <= wdata;
                tx_buffer_ready_flag <= 1'b0;
            end else if (tx_xfer) begin
                o_tx_shift_reg       <= tx_data_buffer;
                tx_buffer_ready_flag <= 1'b1;
            end
        end
    end

    // Interrupt requests and sticky status
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_irq   <= 1'b0;
            o_tx_irq   <= 1'b0;
            irq_status <= 2'h0;
        end else begin
            o_rx_irq <= rx_load && control[CT_RX_IRQ_EN];
            o_tx_irq <= tx_xfer && control[CT_TX_IRQ_EN];
            for (int i = 0; i < 2; i++) begin
                if ((i == IS_RX) ? (rx_load && control[CT_RX_IRQ_EN])
                                 : (tx_xfer && control[CT_TX_IRQ_EN]))
                    irq_status[i] <= 1'b1;
                else if (acc_wr && req_idx == REG_IRQ_STAT_IDX && wdata[i])
                    irq_status[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_irq             <= 1'b0;
            o_rx_irq_low_prio <= 1'b0;
            o_tx_irq_low_prio <= 1'b0;
            o_freeze          <= 1'b0;
        end else begin
            o_irq <= |(irq_status & irq_mask);
            o_tx_irq_low_prio <= irq_priority[PR_TX_LEVEL];
            o_rx_irq_low_prio <= irq_priority[PR_RX_LEVEL];
            o_freeze <= freeze_now;
        end
    end

    // Pin multiplexing
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_pin    <= 1'b0;
            o_tx_pin_oe <= 1'b0;
            o_rx_pin    <= 1'b0;
            o_rx_pin_oe <= 1'b0;
            o_rx_serial <= 1'b1;
        end else begin
            if (pin_control[PC_TX_FUNC]) begin
                o_tx_pin    <= i_tx_serial;
                o_tx_pin_oe <= 1'b1;
            end else begin
                o_tx_pin    <= pin_control[PC_TX_OUT];
                o_tx_pin_oe <= pin_control[PC_TX_DIR];
            end
            o_rx_pin    <= pin_control[PC_RX_OUT];
            o_rx_pin_oe <= !pin_control[PC_RX_FUNC] && pin_control[PC_RX_DIR];
            o_rx_serial <= pin_control[PC_RX_FUNC] ? i_rx_pin : 1'b1;
        end
    end

endmodule

// *** verification/asbp_partner.sv ***
`timescale 1ns/1ps
module asbp_partner
    import asbp_pkg::*;
(
    // Clock and core hand-over
    input  wire logic i_sys_clk,
    input  wire logic i_tx_load,
    input  wire logic i_stall,
    // Shifter side
    output asbp_rx_char_s o_rx_char,
    output logic          o_line_idle,
    output logic          o_shift_free,
    output logic          o_busy
);
    logic [3:0] busy_cnt = 4'h0;

    initial begin
        o_rx_char = '0;
        o_line_idle = 1'b0;
    end
    // A loaded shifter stays busy for six cycles, so freeze can be seen waiting
    always @(posedge i_sys_clk) begin
        if (i_tx_load)
            busy_cnt <= 4'h6;
        else if (busy_cnt != 4'h0)
            busy_cnt <= busy_cnt - 4'h1;
    end
    assign o_busy = (busy_cnt != 4'h0);
    assign o_shift_free = !o_busy && !i_stall;

    task automatic send_char(input logic a, input logic [7:0] d);
        @(posedge i_sys_clk);
        o_rx_char <= '{valid: 1'b1, addr_bit: a, data: d};
        @(posedge i_sys_clk);
        o_rx_char <= '0;
    endtask

    task automatic send_idle();
        @(posedge i_sys_clk);
        o_line_idle <= 1'b1;
        @(posedge i_sys_clk);
        o_line_idle <= 1'b0;
    endtask
endmodule

// *** verification/asbp_chk.sv ***
`timescale 1ns/1ps
module asbp_chk
    import asbp_pkg::*;
(
    // Clock and reset
    input wire logic          i_sys_clk,
    input wire logic          i_rst_n,
    // Bus
    input wire logic          i_avs_read,
    input wire logic          i_avs_write,
    input wire logic          o_avs_waitrequest,
    input wire logic [31:0]   o_avs_readdata,
    // Shifters, pins, interrupts
    input wire asbp_rx_char_s i_rx_char,
    input wire logic          i_suspend,
    input wire logic          i_shift_busy,
    input wire logic          o_freeze,
    input wire logic          o_tx_load,
    input wire logic          o_tx_irq,
    input wire logic          o_rx_irq,
    input wire logic          o_rx_pin_oe,
    input wire logic          o_rx_serial
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_taken;
        (i_avs_read || i_avs_write) && o_avs_waitrequest;
    endsequence
    sequence s_answer;
        !o_avs_waitrequest ##1 o_avs_waitrequest;
    endsequence

    AST_ANSWER: assert property (s_taken |=> s_answer)
        else $error("bus answer not one cycle");
    AST_RDATA_HI: assert property (!o_avs_waitrequest |-> o_avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_RX_IRQ: assert property (o_rx_irq |-> $past(i_rx_char.valid))
        else $error("receive request without a load");
    AST_TX_IRQ: assert property (o_tx_irq |-> o_tx_load)
        else $error("transmit request without transfer");
    AST_TX_LOAD: assert property (o_tx_load |=> !o_tx_load)
        else $error("transfer pulse too long");
    AST_RX_PIN: assert property (o_rx_pin_oe |-> o_rx_serial)
        else $error("receive shifter fed while pin is general output");
    AST_FREEZE: assert property (i_suspend && !i_shift_busy |=> o_freeze)
        else $error("no freeze with idle shifters");
    AST_THAW: assert property (!i_suspend |=> !o_freeze)
        else $error("freeze without suspend");
endmodule

bind asbp_core asbp_chk u_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest),
    .o_avs_readdata(o_avs_readdata), .i_rx_char(i_rx_char), .i_suspend(i_suspend),
    .i_shift_busy(i_shift_busy), .o_freeze(o_freeze), .o_tx_load(o_tx_load),
    .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq), .o_rx_pin_oe(o_rx_pin_oe),
    .o_rx_serial(o_rx_serial)
);

// *** verification/test_async_serial_buffers_pins.sv ***
`timescale 1ns/1ps
module test_async_serial_buffers_pins;
    import asbp_pkg::*;

    logic          i_sys_clk = 1'b0;
    logic          i_rst_n = 1'b0;
    logic [17:0]   i_avs_address = '0;
    logic          i_avs_read = 1'b0;
    logic          i_avs_write = 1'b0;
    logic [31:0]   i_avs_writedata = '0;
    logic          i_suspend = 1'b0;
    logic          stall = 1'b0;
    logic          ext_tx = 1'b0;
    logic          ext_rx = 1'b0;
    logic [31:0]   o_avs_readdata;
    logic [1:0]    o_avs_response;
    logic [1:0]    rsp;
    logic [7:0]    o_tx_shift_reg;
    logic          o_avs_waitrequest, o_tx_load, o_freeze, o_tx_pin, o_tx_pin_oe;
    logic          o_rx_pin, o_rx_pin_oe, o_rx_serial, o_rx_irq, o_tx_irq, o_irq;
    logic          o_rx_irq_low_prio, o_tx_irq_low_prio, line_idle, shift_free, busy;
    asbp_rx_char_s rx_char;
    int            n_fail = 0;
    int            checked = 0;
    // Pins float to the far side's level unless the core drives them
    wire logic     tx_wire = o_tx_pin_oe ? o_tx_pin : ext_tx;
    wire logic     rx_wire = o_rx_pin_oe ? o_rx_pin : ext_rx;

    always #12.5 i_sys_clk = ~i_sys_clk;

    asbp_core dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
        .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .o_avs_response(o_avs_response), .i_rx_char(rx_char), .i_rx_line_idle(line_idle),
        .i_tx_shift_free(shift_free), .o_tx_load(o_tx_load), .o_tx_shift_reg(o_tx_shift_reg),
        .i_tx_serial(1'b1), .i_suspend(i_suspend), .i_shift_busy(busy), .o_freeze(o_freeze),
        .i_tx_pin(tx_wire), .o_tx_pin(o_tx_pin), .o_tx_pin_oe(o_tx_pin_oe),
        .i_rx_pin(rx_wire), .o_rx_pin(o_rx_pin), .o_rx_pin_oe(o_rx_pin_oe),
        .o_rx_serial(o_rx_serial), .o_rx_irq(o_rx_irq), .o_tx_irq(o_tx_irq),
        .o_rx_irq_low_prio(o_rx_irq_low_prio), .o_tx_irq_low_prio(o_tx_irq_low_prio),
        .o_irq(o_irq)
    );

    asbp_partner u_prt (
        .i_sys_clk(i_sys_clk), .i_tx_load(o_tx_load), .i_stall(stall), .o_rx_char(rx_char),
        .o_line_idle(line_idle), .o_shift_free(shift_free), .o_busy(busy)
    );

    task automatic close_out();
        $display("compares %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] d,
                       output logic [7:0] q);
        int n = 0;
        @(posedge i_sys_clk);
        i_avs_address <= {2'b00, idx};
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_writedata <= {24'h0, d};
        do begin
            @(posedge i_sys_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 50);
        if (o_avs_waitrequest !== 1'b0) begin
            n_fail++;
            close_out();
        end
        q = o_avs_readdata[7:0];
        rsp = o_avs_response;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] e, input string what);
        logic [7:0] q;
        acc(1'b0, idx, 8'h00, q);
        cmp(what, e, q);
    endtask

    task automatic wait_load();
        for (int n = 0; n < 20 && o_tx_load !== 1'b1; n++)
            @(posedge i_sys_clk);
        if (o_tx_load !== 1'b1) begin
            n_fail++;
            close_out();
        end
    endtask

    task automatic t_reset();
        rdc(REG_PIN_CTRL_IDX, 8'h00, "pin_control");
        rdc(REG_PRIO_IDX, 8'h00, "irq_priority");
        rdc(REG_RX_PEEK_IDX, 8'h00, "rx_peek_buffer");
        rdc(REG_RX_DATA_IDX, 8'h00, "rx_data_buffer");
        rdc(REG_STATUS_IDX, 8'h02, "status");
        $display("t_reset done");
    endtask

    task automatic t_rx();
        wr(REG_CONTROL_IDX, 8'h02);
        wr(REG_IRQ_MASK_IDX, 8'h01);
        u_prt.send_char(1'b0, 8'ha5);
        rdc(REG_STATUS_IDX, 8'h03, "status");
        cmp("irq", 8'h01, {7'h0, o_irq});
        rdc(REG_RX_PEEK_IDX, 8'ha5, "rx_peek_buffer");
        rdc(REG_STATUS_IDX, 8'h03, "status");
        rdc(REG_RX_DATA_IDX, 8'ha5, "rx_data_buffer");
        rdc(REG_STATUS_IDX, 8'h02, "status");
        u_prt.send_char(1'b0, 8'h3c);
        u_prt.send_char(1'b0, 8'hc3);
        rdc(REG_RX_DATA_IDX, 8'hc3, "rx_data_buffer");
        rdc(REG_STATUS_IDX, 8'h0a, "status");
        rdc(REG_IRQ_STAT_IDX, 8'h01, "irq status");
        wr(REG_IRQ_MASK_IDX, 8'h00);
        repeat (2) @(posedge i_sys_clk);
        cmp("irq masked", 8'h00, {7'h0, o_irq});
        wr(REG_IRQ_STAT_IDX, 8'h01);
        rdc(REG_IRQ_STAT_IDX, 8'h00, "irq status");
        wr(REG_CONTROL_IDX, 8'h01);
        wr(REG_CONTROL_IDX, 8'h00);
        rdc(REG_STATUS_IDX, 8'h02, "status");
        $display("t_rx done");
    endtask

    task automatic t_wake();
        logic [7:0] q;
        wr(REG_CONTROL_IDX, 8'h08);
        u_prt.send_char(1'b1, 8'h11);
        rdc(REG_STATUS_IDX, 8'h07, "status");
        u_prt.send_char(1'b0, 8'h22);
        rdc(REG_STATUS_IDX, 8'h0b, "status");
        wr(REG_CONTROL_IDX, 8'h11);
        wr(REG_CONTROL_IDX, 8'h10);
        u_prt.send_idle();
        rdc(REG_STATUS_IDX, 8'h06, "status");
        acc(1'b0, REG_RX_DATA_IDX, 8'h00, q);
        rdc(REG_STATUS_IDX, 8'h02, "status");
        $display("t_wake done");
    endtask

    task automatic t_tx();
        stall <= 1'b1;
        wr(REG_CONTROL_IDX, 8'h04);
        wr(REG_IRQ_MASK_IDX, 8'h02);
        wr(REG_TX_DATA_IDX, 8'h3c);
        rdc(REG_STATUS_IDX, 8'h00, "status");
        stall <= 1'b0;
        wait_load();
        cmp("tx_shift_reg", 8'h3c, o_tx_shift_reg);
        cmp("tx irq", 8'h01, {7'h0, o_tx_irq});
        rdc(REG_STATUS_IDX, 8'h02, "status");
        rdc(REG_IRQ_STAT_IDX, 8'h02, "irq status");
        cmp("irq", 8'h01, {7'h0, o_irq});
        wr(REG_IRQ_STAT_IDX, 8'h02);
        repeat (2) @(posedge i_sys_clk);
        cmp("irq cleared", 8'h00, {7'h0, o_irq});
        $display("t_tx done");
    endtask

    task automatic t_pins();
        wr(REG_PIN_CTRL_IDX, 8'h55);
        rdc(REG_PIN_CTRL_IDX, 8'hdd, "pin_control");
        cmp("pins", 8'h0f, {4'h0, o_tx_pin_oe, o_tx_pin, o_rx_pin_oe, o_rx_pin});
        wr(REG_PIN_CTRL_IDX, 8'h10);
        ext_rx <= 1'b1;
        rdc(REG_PIN_CTRL_IDX, 8'h18, "pin_control");
        cmp("pins", 8'h08, {4'h0, o_tx_pin_oe, o_tx_pin, o_rx_pin_oe, o_rx_pin});
        wr(REG_PIN_CTRL_IDX, 8'h22);
        ext_rx <= 1'b0;
        rdc(REG_PIN_CTRL_IDX, 8'ha2, "pin_control");
        cmp("serial", 8'h0c, {4'h0, o_tx_pin_oe, o_tx_pin, o_rx_pin_oe, o_rx_serial});
        wr(REG_PIN_CTRL_IDX, 8'h00);
        $display("t_pins done");
    endtask

    task automatic t_prio();
        logic [7:0] q;
        wr(REG_PRIO_IDX, 8'hff);
        rdc(REG_PRIO_IDX, 8'h70, "irq_priority");
        cmp("levels", 8'h03, {6'h0, o_tx_irq_low_prio, o_rx_irq_low_prio});
        wr(REG_PRIO_IDX, 8'h40);
        repeat (2) @(posedge i_sys_clk);
        cmp("levels", 8'h02, {6'h0, o_tx_irq_low_prio, o_rx_irq_low_prio});
        wr(REG_TX_DATA_IDX, 8'h5a);
        wait_load();
        i_suspend <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        cmp("freeze busy", 8'h00, {7'h0, o_freeze});
        repeat (8) @(posedge i_sys_clk);
        cmp("freeze done", 8'h01, {7'h0, o_freeze});
        i_suspend <= 1'b0;
        wr(REG_PRIO_IDX, 8'h10);
        wr(REG_TX_DATA_IDX, 8'ha5);
        wait_load();
        i_suspend <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        cmp("freeze now", 8'h01, {7'h0, o_freeze});
        i_suspend <= 1'b0;
        acc(1'b0, 16'h7058, 8'h00, q);
        cmp("unmapped data", 8'h00, q);
        cmp("response", 8'h03, {6'h0, rsp});
        $display("t_prio done");
    endtask

    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset();
        t_rx();
        t_wake();
        t_tx();
        t_pins();
        t_prio();
        close_out();
    end
endmodule
